// >>> rtl/hpp_oc_filter.sv
// Over-current pin synchroniser and spike filter for one port
module hpp_oc_filter #(
	parameter int unsigned FILT_CYC = 200
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic clk_en,
	input  wire logic oc_pin_n,
	output logic      oc_active
);
	localparam int unsigned CW = $clog2(FILT_CYC + 1);

	logic          sync1_r;
	logic          sync2_r;
	logic [CW-1:0] cnt_r;
	logic          same;

	// High while the synchronised pin agrees with the present verdict
	assign same = (sync2_r == ~oc_active);

	// Two-stage synchroniser, then a stability counter; a spike resets the count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r   <= 1'b1;
			sync2_r   <= 1'b1;
			cnt_r     <= '0;
			oc_active <= 1'b0;
		end else if (clk_en) begin
			sync1_r <= oc_pin_n;
			sync2_r <= sync1_r;
			if (same) begin
				cnt_r <= '0; // RL5
			end else if (cnt_r == CW'(FILT_CYC - 1)) begin
				cnt_r     <= '0;
				oc_active <= ~sync2_r; // RL3
			end else begin
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end
endmodule

// >>> rtl/hpp_timebase.sv
// Reference clock checker and 48/12 MHz timing strobe generator
module hpp_timebase (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic clk_en,
	input  wire logic ref_pin,
	output logic      ref_level,
	output logic      locked,
	output logic      tick_fast,
	output logic      tick_slow
);
	import hpp_pkg::*;

	logic       s1_r;
	logic       s2_r;
	logic       prev_r;
	logic [7:0] per_r;
	logic [3:0] good_r;
	logic [4:0] acc_r;
	logic [1:0] div_r;
	logic       rise;
	logic       per_ok;
	logic [5:0] acc_sum;

	assign ref_level = s2_r;
	assign rise      = s2_r & ~prev_r;
	assign per_ok    = (per_r >= 8'(REF_PER_MIN)) && (per_r <= 8'(REF_PER_MAX));
	assign acc_sum   = {1'b0, acc_r} + 6'(FAST_MHZ / 8);

	// Lock needs several in-window reference periods in a row
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r   <= 1'b0;
			s2_r   <= 1'b0;
			prev_r <= 1'b0;
			per_r  <= '0;
			good_r <= '0;
			locked <= 1'b0;
		end else if (clk_en) begin
			s1_r   <= ref_pin;
			s2_r   <= s1_r;
			prev_r <= s2_r;
			if (rise) begin
				per_r <= 8'h01;
				if (!per_ok) begin
					good_r <= '0;
					locked <= 1'b0;
				end else if (good_r == 4'(LOCK_PERIODS - 1)) begin
					locked <= 1'b1; // RL11
				end else begin
					good_r <= good_r + 1'b1;
				end
			end else if (per_r == 8'hFF) begin
				good_r <= '0; // Reference stopped
				locked <= 1'b0;
			end else begin
				per_r <= per_r + 1'b1;
			end
		end
	end

	// Fractional divider: 48/200 = 6/25, slow strobe every fourth fast strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_r     <= '0;
			div_r     <= '0;
			tick_fast <= 1'b0;
			tick_slow <= 1'b0;
		end else if (clk_en) begin
			tick_fast <= 1'b0;
			tick_slow <= 1'b0;
			if (!locked) begin
				acc_r <= '0;
				div_r <= '0;
			end else if (acc_sum >= 6'(PCLK_MHZ / 8)) begin
				acc_r     <= 5'(acc_sum - 6'(PCLK_MHZ / 8));
				tick_fast <= 1'b1; // RL11
				div_r     <= div_r + 1'b1;
				tick_slow <= (div_r == 2'(FAST_PER_SLOW - 1)); // RL14
			end else begin
				acc_r <= acc_sum[4:0];
			end
		end
	end
endmodule

// >>> rtl/hpp_top.sv
// Hub port power, over-current, suspend and strap control with APB registers
module hpp_top #(
	parameter int unsigned PORTS    = hpp_pkg::NUM_PORTS,
	parameter int unsigned FILT_CYC = hpp_pkg::OC_FILTER_CYC
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              clk_en,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              config_memory_select_n,
	input  wire logic [PORTS-1:0]  port_overcurrent_n,
	output logic      [PORTS-1:0]  port_power_enable_n,
	output logic                   suspend_status_out,
	input  wire logic              factory_test_strap,
	input  wire logic              pll_test_strap,
	input  wire logic              reference_clock_in,
	output logic                   reference_clock_out,
	output logic                   rom_serial_clock,
	output logic                   rom_serial_clock_oe,
	input  wire logic              rom_serial_data_in,
	output logic                   rom_serial_data_out,
	output logic                   rom_serial_data_oe,
	output logic                   tick_48,
	output logic                   tick_12
);
	import hpp_pkg::*;

	// Synchronisers for strap and data pins
	logic             memsel_s1_r;
	logic             memsel_s2_r;
	logic             ftest_s1_r;
	logic             ftest_s2_r;
	logic             ptest_s1_r;
	logic             ptest_s2_r;
	logic             rdata_s1_r;
	logic             rdata_s2_r;

	// Captured straps
	logic [1:0]       strap_wait_r;
	logic             strap_ok_r;
	logic             mem_dis_r;
	logic             shared_strap_r;
	logic             ftest_r;
	logic             ptest_r;

	// Registers
	logic [31:0]      ctrl_r;
	logic [PORTS-1:0] oc_evt_r;
	logic [PORTS-1:0] oc_evt_nxt;
	logic [2:0]       rom_r;

	// Internal status
	logic [PORTS-1:0] oc_filt;
	logic             ref_level;
	logic             locked;
	logic             tick_fast;
	logic             tick_slow;

	// Decode
	logic             acc_phase;
	logic             wr_done;
	logic             sel_ctrl;
	logic             sel_stat;
	logic             sel_evt;
	logic             sel_rom;
	logic             mapped;
	logic             shared_mode;
	logic             any_evt;
	logic [PORTS-1:0] pwr_on;
	logic [31:0]      stat_word;
	logic [31:0]      rd_mux;

	// One filter per port pin
	genvar gi;
	generate
		for (gi = 0; gi < PORTS; gi++) begin : g_oc
			hpp_oc_filter #(
				.FILT_CYC (FILT_CYC)
			) u_filt (
				.pclk      (pclk),
				.presetn   (presetn),
				.clk_en    (clk_en),
				.oc_pin_n  (port_overcurrent_n[gi]),
				.oc_active (oc_filt[gi])
			);
		end
	endgenerate

	hpp_timebase u_tb (
		.pclk      (pclk),
		.presetn   (presetn),
		.clk_en    (clk_en),
		.ref_pin   (reference_clock_in),
		.ref_level (ref_level),
		.locked    (locked),
		.tick_fast (tick_fast),
		.tick_slow (tick_slow)
	);

	// APB decode; every access waits one cycle so the answer comes from flops
	assign acc_phase = psel & penable;
	assign wr_done   = acc_phase & pready & pwrite & clk_en;
	assign sel_ctrl  = (paddr == CTRL_OFS);
	assign sel_stat  = (paddr == STATUS_OFS);
	assign sel_evt   = (paddr == OC_EVT_OFS);
	assign sel_rom   = (paddr == ROM_OFS);
	assign mapped    = sel_ctrl | sel_stat | sel_evt | sel_rom;

	// Shared mode comes from the strap, or from software when the memory owns the pin
	assign shared_mode = mem_dis_r ? shared_strap_r : ctrl_r[CTRL_SHARED_SW]; // RL13
	assign any_evt     = |oc_evt_r; // RL4

	// Power is requested by software and withdrawn by latched over-current events
	assign pwr_on = shared_mode ?
		{PORTS{ctrl_r[CTRL_PWR_LSB] & ~any_evt}} : // RL12
		(ctrl_r[CTRL_PWR_LSB +: PORTS] & ~oc_evt_r); // RL15

	// Hardware sets win over a write-one clear landing in the same cycle
	assign oc_evt_nxt = (oc_evt_r & ~((wr_done & sel_evt) ? pwdata[PORTS-1:0] : '0))
		| oc_filt;

	assign stat_word = 32'(oc_filt) << STAT_OC_LSB
		| 32'(pwr_on) << STAT_PWR_LSB
		| 32'(shared_mode) << STAT_SHARED
		| 32'(!mem_dis_r) << STAT_MEM_EN
		| 32'(locked) << STAT_LOCKED
		| 32'(ftest_r) << STAT_FTEST
		| 32'(ptest_r) << STAT_PTEST
		| 32'(strap_ok_r) << STAT_STRAP_OK;

	assign rd_mux = sel_ctrl ? ctrl_r :
		sel_stat ? stat_word :
		sel_evt  ? 32'(oc_evt_r) :
		sel_rom  ? (32'(rom_r) | (32'(rdata_s2_r) << ROM_DIN_BIT)) :
		32'h0000_0000;

	// Pin synchronisers; first stages feed only the second stages
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			memsel_s1_r <= 1'b1;
			memsel_s2_r <= 1'b1;
			ftest_s1_r  <= 1'b0;
			ftest_s2_r  <= 1'b0;
			ptest_s1_r  <= 1'b0;
			ptest_s2_r  <= 1'b0;
			rdata_s1_r  <= 1'b0;
			rdata_s2_r  <= 1'b0;
		end else if (clk_en) begin
			memsel_s1_r <= config_memory_select_n;
			memsel_s2_r <= memsel_s1_r;
			ftest_s1_r  <= factory_test_strap;
			ftest_s2_r  <= ftest_s1_r;
			ptest_s1_r  <= pll_test_strap;
			ptest_s2_r  <= ptest_s1_r;
			rdata_s1_r  <= rom_serial_data_in;
			rdata_s2_r  <= rdata_s1_r;
		end
	end

	// Straps are taken once, after the synchronisers have filled following reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_wait_r   <= '0; // RL7
			strap_ok_r     <= 1'b0;
			mem_dis_r      <= 1'b1;
			shared_strap_r <= 1'b0;
			ftest_r        <= 1'b0;
			ptest_r        <= 1'b0;
		end else if (clk_en && !strap_ok_r) begin
			if (strap_wait_r == 2'h3) begin
				strap_ok_r     <= 1'b1;
				mem_dis_r      <= memsel_s2_r; // RL1
				shared_strap_r <= rdata_s2_r; // RL13
				ftest_r        <= ftest_s2_r; // RL10
				ptest_r        <= ptest_s2_r; // RL10
			end else begin
				strap_wait_r <= strap_wait_r + 1'b1;
			end
		end
	end

	// APB answer: ready one cycle into the access phase, error on unmapped offsets
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (clk_en) begin
			pready  <= acc_phase & ~pready;
			pslverr <= acc_phase & ~pready & ~mapped;
			prdata  <= (acc_phase & ~pready & ~pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// Software registers; the status word is read-only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r   <= CTRL_RESET; // RL7
			oc_evt_r <= '0;
			rom_r    <= ROM_RESET;
		end else if (clk_en) begin
			oc_evt_r <= oc_evt_nxt;
			if (wr_done && sel_ctrl) begin
				ctrl_r <= pwdata;
			end
			if (wr_done && sel_rom) begin
				rom_r <= pwdata[2:0];
			end
		end
	end

	// Pin outputs, all registered; memory pins float whenever the strap disables them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_power_enable_n <= '1; // RL6
			suspend_status_out  <= 1'b0;
			reference_clock_out <= 1'b1;
			rom_serial_clock    <= 1'b0;
			rom_serial_clock_oe <= 1'b0;
			rom_serial_data_out <= 1'b0;
			rom_serial_data_oe  <= 1'b0;
			tick_48             <= 1'b0;
			tick_12             <= 1'b0;
		end else if (clk_en) begin
			port_power_enable_n <= ~pwr_on; // RL6
			suspend_status_out  <= ctrl_r[CTRL_SUSPEND]; // RL9
			reference_clock_out <= ~ref_level;
			rom_serial_clock    <= rom_r[ROM_CLK_BIT];
			rom_serial_clock_oe <= strap_ok_r & ~mem_dis_r; // RL2
			rom_serial_data_out <= rom_r[ROM_DOUT_BIT];
			rom_serial_data_oe  <= strap_ok_r & ~mem_dis_r & rom_r[ROM_DOE_BIT]; // RL1
			tick_48             <= tick_fast & ~ctrl_r[CTRL_SUSPEND]; // RL14
			tick_12             <= tick_slow & ~ctrl_r[CTRL_SUSPEND]; // RL14
		end
	end
endmodule

// >>> shared/hpp_pkg.sv
// Constants shared by the hub port power and strap block
// Overview of operation
// RL1 - A high memory-select strap disables the serial configuration-memory pins.
// RL2 - A low memory-select strap turns the two shared pins into memory clock and data.
// RL3 - Each port over-current input is active low, one per port in per-port mode.
// RL4 - In shared mode the board ties all over-current inputs together, any may be obeyed.
// RL5 - Every over-current input is noise filtered so short spikes are rejected.
// RL6 - Each port power-enable output is push-pull, low for power on and high for off.
// RL7 - While the active-low reset is asserted all logic is held in its initial state.
// RL8 - The system asserts the active-low reset during power-up.
// RL9 - The suspend status output is high in suspend and low in normal operation.
// RL10 - The board ties both production-test inputs to ground; they have no system function.
// RL11 - The 48 MHz and 12 MHz logic timing is derived from a 6 MHz 50 percent reference; the code divides pclk, the reference only gates it via lock.
// RL12 - Shared mode switches all port power together and any over-current powers all off.
// RL13 - With the memory disabled the shared data pin is read as the shared-mode strap.
// RL14 - The 48 MHz timing samples upstream data and keeps the 12 MHz clock aligned.
// RL15 - In per-port mode a filtered over-current turns off only that port's power.
package hpp_pkg;

	localparam int unsigned NUM_PORTS = 4;

	// Clock and timing
	localparam int unsigned PCLK_MHZ       = 200;
	localparam int unsigned OC_FILTER_NS   = 1000;
	localparam int unsigned OC_FILTER_CYC  = (OC_FILTER_NS * PCLK_MHZ + 999) / 1000;
	localparam int unsigned REF_MHZ        = 6;
	localparam int unsigned FAST_MHZ       = 48;
	localparam int unsigned SLOW_MHZ       = 12;
	// Reference period window in pclk cycles (nominal 33.3)
	localparam int unsigned REF_PER_MIN    = (PCLK_MHZ / REF_MHZ) - 3;
	localparam int unsigned REF_PER_MAX    = (PCLK_MHZ / REF_MHZ) + 4;
	localparam int unsigned LOCK_PERIODS   = 8;
	localparam int unsigned FAST_PER_SLOW  = FAST_MHZ / SLOW_MHZ;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] OC_EVT_OFS = 8'h08;
	localparam logic [7:0] ROM_OFS    = 8'h0C;

	// Control register fields
	localparam int unsigned CTRL_PWR_LSB    = 0;
	localparam int unsigned CTRL_SUSPEND    = 8;
	localparam int unsigned CTRL_SHARED_SW  = 9;
	localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;

	// Status register fields
	localparam int unsigned STAT_OC_LSB     = 0;
	localparam int unsigned STAT_PWR_LSB    = 4;
	localparam int unsigned STAT_SHARED     = 8;
	localparam int unsigned STAT_MEM_EN     = 9;
	localparam int unsigned STAT_LOCKED     = 10;
	localparam int unsigned STAT_FTEST      = 11;
	localparam int unsigned STAT_PTEST      = 12;
	localparam int unsigned STAT_STRAP_OK   = 13;

	// Memory pin register fields
	localparam int unsigned ROM_CLK_BIT     = 0;
	localparam int unsigned ROM_DOUT_BIT    = 1;
	localparam int unsigned ROM_DOE_BIT     = 2;
	localparam int unsigned ROM_DIN_BIT     = 8;
	localparam logic [2:0]  ROM_RESET       = 3'h0;

endpackage

// >>> sim/hpp_chk.sv
// Port-level checker for the hub port power and strap block
module hpp_chk #(
	parameter int unsigned PORTS    = 4,
	parameter int unsigned FILT_CYC = 200
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      prdata,
	input  wire logic             pready,
	input  wire logic             pslverr,
	input  wire logic             config_memory_select_n,
	input  wire logic [PORTS-1:0] port_overcurrent_n,
	input  wire logic [PORTS-1:0] port_power_enable_n,
	input  wire logic             suspend_status_out,
	input  wire logic             rom_serial_clock_oe,
	input  wire logic             rom_serial_data_oe,
	input  wire logic             tick_48,
	input  wire logic             tick_12
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] oc_cnt_r;
	logic [7:0] oc_cnt_nxt;
	logic [2:0] wr_hist_r;
	logic       wr_done;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Saturating run length of a low port 0 flag; a spike resets it
	assign oc_cnt_nxt = port_overcurrent_n[0] ? 8'h00 : (&oc_cnt_r ? oc_cnt_r : oc_cnt_r + 8'h01);
	assign wr_done = psel && penable && pready && pwrite && (paddr == 8'h00);
	// Helper history kept so a late suspend edge still finds its write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oc_cnt_r <= 8'h00;
			wr_hist_r <= 3'h0;
		end else begin
			oc_cnt_r <= oc_cnt_nxt;
			wr_hist_r <= {wr_hist_r[1:0], wr_done};
		end
	end
	sequence s_access_start;
		psel && penable && !pready;
	endsequence
	chk_strap_mem_off: assert property (config_memory_select_n |->
		!rom_serial_clock_oe && !rom_serial_data_oe) else $error("memory pins driven while off");
	chk_oc_power_off: assert property (oc_cnt_r == 8'(FILT_CYC + 8) |->
		port_power_enable_n[0]) else $error("port 0 still powered during over-current");
	chk_reset_init: assert property ($rose(presetn) |-> &port_power_enable_n &&
		!suspend_status_out && !pready) else $error("outputs not initial after reset");
	chk_suspend_cause: assert property ($rose(suspend_status_out) |-> |wr_hist_r)
		else $error("suspend rose without a control write");
	chk_ticks_quiet: assert property (suspend_status_out && $past(suspend_status_out) &&
		$past(suspend_status_out, 2) |-> !tick_48 && !tick_12) else $error("ticks in suspend");
	chk_apb_answer: assert property (s_access_start |=> pready) else $error("no answer");
	chk_pready_pulse: assert property (pready |=> !pready) else $error("pready too long");
	chk_slverr_pair: assert property (pslverr |-> pready && (prdata == 32'h0000_0000))
		else $error("error without pready or with data");
endmodule
bind hpp_top hpp_chk #(.PORTS(PORTS), .FILT_CYC(FILT_CYC)) chk_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .config_memory_select_n(config_memory_select_n),
	.port_overcurrent_n(port_overcurrent_n), .port_power_enable_n(port_power_enable_n),
	.suspend_status_out(suspend_status_out), .rom_serial_clock_oe(rom_serial_clock_oe),
	.rom_serial_data_oe(rom_serial_data_oe), .tick_48(tick_48), .tick_12(tick_12));

// >>> sim/hpp_partner.sv
// Board model: power switches, memory data pin, crystal and test straps
module hpp_partner (
	input  wire logic       shared_board,
	input  wire logic       mem_sel_n,
	input  wire logic [3:0] fault,
	input  wire logic       rom_serial_data_out,
	input  wire logic       rom_serial_data_oe,
	output logic      [3:0] port_overcurrent_n,
	output logic            rom_serial_data_in,
	output logic            reference_clock_in,
	output logic            factory_test_strap,
	output logic            pll_test_strap
);
	timeunit 1ns;
	timeprecision 1ps;
	// Switch flags are low while a fault lasts; shared boards wire them together
	assign port_overcurrent_n = shared_board ? {4{~|fault}} : ~fault;
	// A released pin falls to the pull-down, or shows the board strap with memory off
	assign rom_serial_data_in = rom_serial_data_oe ? rom_serial_data_out : (mem_sel_n & shared_board);
	assign factory_test_strap = 1'b0;
	assign pll_test_strap = 1'b0;
	// Free-running crystal, 50 percent duty, period 166 ns
	initial begin
		reference_clock_in = 1'b0;
		forever #83 reference_clock_in = ~reference_clock_in;
	end
endmodule

// >>> sim/hpp_top_test.sv
// Self-checking bench for the hub port power and strap block
module hpp_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import hpp_pkg::*;
	localparam int unsigned FILT = 4;
	logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
	logic        sel_n, shared_b, susp, rck, rck_oe, rdi, rdo, rdoe, refin, fts, pts;
	logic        t48, t12, rco;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:0]  fault, oc_n, pwr_n;
	int          bad_count, comparisons, cyc;
	hpp_top #(.FILT_CYC(FILT)) dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .config_memory_select_n(sel_n),
		.port_overcurrent_n(oc_n), .port_power_enable_n(pwr_n), .suspend_status_out(susp),
		.factory_test_strap(fts), .pll_test_strap(pts), .reference_clock_in(refin),
		.reference_clock_out(rco), .rom_serial_clock(rck), .rom_serial_clock_oe(rck_oe),
		.rom_serial_data_in(rdi), .rom_serial_data_out(rdo), .rom_serial_data_oe(rdoe),
		.tick_48(t48), .tick_12(t12));
	hpp_partner board_u (.shared_board(shared_b), .mem_sel_n(sel_n), .fault(fault),
		.rom_serial_data_out(rdo), .rom_serial_data_oe(rdoe), .port_overcurrent_n(oc_n),
		.rom_serial_data_in(rdi), .reference_clock_in(refin), .factory_test_strap(fts),
		.pll_test_strap(pts));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task automatic test_done();
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Ceiling far above the several hundred cycles the sequence needs
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 8000) begin
			bad_count++;
			test_done();
		end
	end
	task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// One APB transfer; request held until pready is sampled high
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		cmp("pready", 32'h1, {31'h0, pready});
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Straps settle before release; outputs checked while reset is held
	task automatic do_reset(logic s, logic g);
		@(posedge pclk);
		presetn <= 1'b0;
		sel_n <= s;
		shared_b <= g;
		fault <= 4'h0;
		repeat (5) @(posedge pclk);
		cmp("rst_pwr", 4'hF, pwr_n);
		cmp("rst_susp", 1'b0, susp);
		presetn <= 1'b1;
		repeat (12) @(posedge pclk);
	endtask
	task automatic t_mem();
		do_reset(1'b0, 1'b0);
		apb(1'b0, STATUS_OFS, 32'h0);
		cmp("stat_straps", 32'h0000_2200, q & 32'h0000_3B00);
		apb(1'b1, ROM_OFS, 32'h0000_0007);
		repeat (2) @(posedge pclk);
		cmp("rom_pins", 4'hF, {rck, rck_oe, rdo, rdoe});
		apb(1'b0, ROM_OFS, 32'h0);
		cmp("rom_echo", 1'b1, q[ROM_DIN_BIT]);
		apb(1'b1, ROM_OFS, 32'h0000_0003);
		// The released pin needs the output flop and both synchroniser stages to show the pull-down
		repeat (4) @(posedge pclk);
		apb(1'b0, ROM_OFS, 32'h0);
		cmp("rom_pulldown", 1'b0, q[ROM_DIN_BIT]);
		apb(1'b1, CTRL_OFS, 32'h0000_0201);
		repeat (2) @(posedge pclk);
		cmp("sw_shared", 4'h0, pwr_n);
	endtask
	task automatic t_port();
		apb(1'b1, CTRL_OFS, 32'h0000_000F);
		repeat (2) @(posedge pclk);
		cmp("pwr_on", 4'h0, pwr_n);
		fault <= 4'h2;
		repeat (2) @(posedge pclk);
		fault <= 4'h0;
		repeat (20) @(posedge pclk);
		cmp("spike", 4'h0, pwr_n);
		fault <= 4'h1;
		repeat (20) @(posedge pclk);
		cmp("pwr_one_off", 4'h1, pwr_n);
		apb(1'b0, STATUS_OFS, 32'h0);
		cmp("stat_oc", 4'h1, q[3:0]);
		fault <= 4'h0;
		repeat (20) @(posedge pclk);
		apb(1'b0, OC_EVT_OFS, 32'h0);
		cmp("oc_sticky", 4'h1, q[3:0]);
		apb(1'b1, OC_EVT_OFS, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		cmp("pwr_back", 4'h0, pwr_n);
	endtask
	// Strobe rates once locked, and the inverted reference echo three edges behind the pin
	task automatic t_ticks();
		int         nf, ns, nr;
		logic [2:0] h;
		nf = 0;
		ns = 0;
		nr = 0;
		h = 3'h0;
		repeat (3) begin
			@(posedge pclk);
			h = {h[1:0], refin};
		end
		repeat (100) begin
			@(posedge pclk);
			if (t48 === 1'b1)
				nf++;
			if (t12 === 1'b1)
				ns++;
			if (rco !== ~h[2])
				nr++;
			h = {h[1:0], refin};
		end
		cmp("tick_48_count", 100 * FAST_MHZ / PCLK_MHZ, nf);
		cmp("tick_12_count", 100 * SLOW_MHZ / PCLK_MHZ, ns);
		cmp("ref_out_echo", 32'h0, nr);
	endtask
	task automatic t_susp();
		apb(1'b1, CTRL_OFS, 32'h0000_010F);
		repeat (3) @(posedge pclk);
		cmp("susp_on", 1'b1, susp);
		apb(1'b1, CTRL_OFS, 32'h0000_000F);
		repeat (300) @(posedge pclk);
		cmp("susp_off", 1'b0, susp);
		apb(1'b0, STATUS_OFS, 32'h0);
		cmp("locked", 1'b1, q[STAT_LOCKED]);
		t_ticks();
		apb(1'b1, CTRL_OFS, 32'h0000_010F);
		repeat (6) @(posedge pclk);
	endtask
	task automatic t_gang();
		do_reset(1'b1, 1'b1);
		cmp("mem_oe_off", 2'b00, {rck_oe, rdoe});
		apb(1'b0, STATUS_OFS, 32'h0);
		cmp("stat_gang", 32'h0000_0100, q & 32'h0000_0300);
		apb(1'b1, CTRL_OFS, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		cmp("gang_on", 4'h0, pwr_n);
		fault <= 4'h8;
		repeat (20) @(posedge pclk);
		cmp("gang_off", 4'hF, pwr_n);
		fault <= 4'h0;
		repeat (20) @(posedge pclk);
		apb(1'b1, OC_EVT_OFS, 32'h0000_000F);
		apb(1'b0, 8'h10, 32'h0);
		cmp("unmapped_err", 32'h1, {31'h0, err});
		cmp("unmapped_data", 32'h0, q);
		cmp("gang_back", 4'h0, pwr_n);
	endtask
	initial begin
		{presetn, psel, penable, pwrite, sel_n, shared_b} = 6'h00;
		clk_en = 1'b1;
		paddr = 8'h00;
		pwdata = 32'h0;
		fault = 4'h0;
		t_mem();
		t_port();
		t_susp();
		t_gang();
		test_done();
	end
endmodule
